// file: hw/lexc_top.sv
// Purpose: Exposure window control for each triggered line acquisition.
// Assumes: Input lines are asynchronous; shaft encoder output is on CORE_CLK.
// Notes:   Exposure output is delayed by base plus debounce for input lines.
`timescale 1ns/1ps
module lexc_top
  import lexc_pkg::*;
#(
  parameter int unsigned BASE_DELAY_CYC = BASE_DLY_DEF_CYC
)
(
  input  wire logic                      CORE_CLK,
  input  wire logic                      SRST,
  input  wire logic [2:0]                EXTERNAL_LINE_TRIGGER_IN,
  input  wire logic                      SHAFT_ENCODER_OUT,
  input  wire logic                      FRAME_TRIGGER_VALID,
  input  wire lexc_pkg::lexc_cfg_t       CFG,
  input  wire logic [2:0][DBC_W-1:0]     DEBOUNCE_CYC,
  output logic                           EXPOSURE_ACTIVE,
  output logic                           LINE_START
);
  import lexc_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_EXPOSE = 2'b01
  } lexc_fsm_t;

  typedef struct packed {
    logic [2:0]       sync1;
    logic [2:0]       sync2;
    logic             src_last;
    lexc_fsm_t        fsm;
    logic [CNT_W-1:0] tcnt;
    logic             nominal;
    logic             start_p;
  } lexc_st_t;

  lexc_st_t         st;
  lexc_st_t         next_st;
  logic             src;
  logic             act_edge;
  logic             end_edge;
  logic             is_line;
  logic [CNT_W-1:0] dly;
  logic [CNT_W-1:0] exp_cyc;
  logic             delayed;

  always_comb
  begin
    case (CFG.trigger_origin_select)
      LEXC_SRC_LINE1: src = st.sync2[0];
      LEXC_SRC_LINE2: src = st.sync2[1];
      LEXC_SRC_LINE3: src = st.sync2[2];
      LEXC_SRC_SHAFT: src = SHAFT_ENCODER_OUT;
      default:        src = st.sync2[0];
    endcase
  end

  assign is_line = (CFG.trigger_origin_select != LEXC_SRC_SHAFT);

  // Active and opposite edges follow the polarity setting
  assign act_edge = (src != st.src_last) && (src == CFG.trigger_edge_polarity);
  assign end_edge = (src != st.src_last) && (src != CFG.trigger_edge_polarity);

  // Duration used as given; the configuring party keeps it inside the model limits
  assign exp_cyc = CNT_W'(CFG.exposure_duration_us) * CNT_W'(CLK_MHZ);

  // Start and end delays are identical: base plus the line debounce for input lines, zero for the shaft
  always_comb
  begin
    dly = '0;
    if (is_line)
    begin
      dly = CNT_W'(BASE_DELAY_CYC);
      case (CFG.trigger_origin_select)
        LEXC_SRC_LINE1: dly = dly + CNT_W'(DEBOUNCE_CYC[0]);
        LEXC_SRC_LINE2: dly = dly + CNT_W'(DEBOUNCE_CYC[1]);
        LEXC_SRC_LINE3: dly = dly + CNT_W'(DEBOUNCE_CYC[2]);
        default:        dly = CNT_W'(BASE_DELAY_CYC);
      endcase
    end
  end

  always_comb
  begin
    next_st          = st;
    next_st.sync1    = EXTERNAL_LINE_TRIGGER_IN;
    next_st.sync2    = st.sync1;
    next_st.src_last = src;
    next_st.start_p  = 1'b0;
    if (st.tcnt != '0)
      next_st.tcnt = st.tcnt - 1'b1;
    case (st.fsm)
      ST_IDLE:
      begin
        // Edges outside a valid frame or with triggering off are dropped
        if (CFG.trigger_enable_setting && FRAME_TRIGGER_VALID && act_edge)
        begin
          next_st.fsm     = ST_EXPOSE;
          next_st.nominal = 1'b1;
          next_st.start_p = 1'b1;
          next_st.tcnt    = exp_cyc;
        end
      end
      ST_EXPOSE:
      begin
        case (CFG.exposure_control_select)
          LEXC_EXP_WIDTH:
          begin
            if (end_edge)
            begin
              next_st.fsm     = ST_IDLE;
              next_st.nominal = 1'b0;
            end
          end
          LEXC_EXP_TIMED:
          begin
            if (st.tcnt <= CNT_W'(1))
            begin
              next_st.fsm     = ST_IDLE;
              next_st.nominal = 1'b0;
            end
          end
          LEXC_EXP_OFF:
          begin
            // Next same-polarity edge closes this line; it opens the next only inside a valid frame with triggering on
            if (act_edge)
            begin
              if (FRAME_TRIGGER_VALID && CFG.trigger_enable_setting)
              begin
                next_st.start_p = 1'b1;
                next_st.nominal = 1'b1;
              end
              else
              begin
                next_st.fsm     = ST_IDLE;
                next_st.nominal = 1'b0;
              end
            end
          end
          default:
          begin
            next_st.fsm     = ST_IDLE;
            next_st.nominal = 1'b0;
          end
        endcase
        if (!CFG.trigger_enable_setting)
        begin
          next_st.fsm     = ST_IDLE;
          next_st.nominal = 1'b0;
        end
      end
      default:
      begin
        next_st.fsm     = ST_IDLE;
        next_st.nominal = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
      st <= '0;
    else
      st <= next_st;
  end

  // Same delay on both edges of the window
  lexc_delay_line #(.W(CNT_W)) u_dly (
    .clk   (CORE_CLK),
    .srst  (SRST),
    .din   (st.nominal),
    .delay (dly),
    .dout  (delayed)
  );

  assign EXPOSURE_ACTIVE = delayed;
  assign LINE_START      = st.start_p;

  a_ignore_invalid: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (st.fsm == ST_IDLE && !FRAME_TRIGGER_VALID) |=> !st.start_p)
    else $error("line start taken outside a valid frame");

  // Timed window: loaded at the start, stepped down, closed when the count runs out
  sequence s_timed_load;
    st.start_p && st.fsm == ST_EXPOSE && CFG.exposure_control_select == LEXC_EXP_TIMED;
  endsequence

  sequence s_timed_run;
    st.fsm == ST_EXPOSE && CFG.exposure_control_select == LEXC_EXP_TIMED && CFG.trigger_enable_setting
    && st.tcnt > CNT_W'(1);
  endsequence

  sequence s_timed_last;
    st.fsm == ST_EXPOSE && CFG.exposure_control_select == LEXC_EXP_TIMED && CFG.trigger_enable_setting
    && st.tcnt == CNT_W'(1);
  endsequence

  a_timed_load: assert property (@(posedge CORE_CLK) disable iff (SRST)
    s_timed_load |-> st.tcnt == CNT_W'(CFG.exposure_duration_us) * CNT_W'(CLK_MHZ))
    else $error("timed exposure count not loaded from the setting");

  a_timed_count: assert property (@(posedge CORE_CLK) disable iff (SRST)
    s_timed_run |=> st.nominal && st.tcnt == $past(st.tcnt) - CNT_W'(1))
    else $error("timed exposure count did not step");

  a_timed_ignore: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (st.fsm == ST_EXPOSE && CFG.exposure_control_select == LEXC_EXP_TIMED && CFG.trigger_enable_setting
     && act_edge && st.tcnt > CNT_W'(1)) |=> st.fsm == ST_EXPOSE && !st.start_p)
    else $error("timed exposure disturbed by a trigger edge");

  a_timed_length: assert property (@(posedge CORE_CLK) disable iff (SRST)
    s_timed_last |=> !st.nominal && st.fsm == ST_IDLE)
    else $error("timed exposure did not close when the count ran out");

  a_width_end: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (st.fsm == ST_EXPOSE && CFG.exposure_control_select == LEXC_EXP_WIDTH && end_edge)
    |=> !st.nominal)
    else $error("width exposure did not end on opposite edge");

  a_width_start: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (st.fsm == ST_IDLE && CFG.trigger_enable_setting && FRAME_TRIGGER_VALID && act_edge)
    |=> st.nominal && st.start_p)
    else $error("exposure did not start on active edge");

  a_off_restart: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (st.fsm == ST_EXPOSE && CFG.exposure_control_select == LEXC_EXP_OFF && act_edge
     && FRAME_TRIGGER_VALID && CFG.trigger_enable_setting) |=> st.start_p && st.nominal)
    else $error("off mode did not chain lines");

  a_disabled_idle: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !CFG.trigger_enable_setting |=> !st.start_p)
    else $error("line started while trigger disabled");

  a_shaft_nodly: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !is_line |-> dly == '0)
    else $error("shaft source given a delay");

  a_line_dly: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (CFG.trigger_origin_select == LEXC_SRC_LINE1)
    |-> dly == CNT_W'(BASE_DELAY_CYC) + CNT_W'(DEBOUNCE_CYC[0]))
    else $error("line delay not base plus debounce");

  a_line2_dly: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (CFG.trigger_origin_select == LEXC_SRC_LINE2)
    |-> dly == CNT_W'(BASE_DELAY_CYC) + CNT_W'(DEBOUNCE_CYC[1]))
    else $error("line 2 delay not base plus debounce");

  a_line3_dly: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (CFG.trigger_origin_select == LEXC_SRC_LINE3)
    |-> dly == CNT_W'(BASE_DELAY_CYC) + CNT_W'(DEBOUNCE_CYC[2]))
    else $error("line 3 delay not base plus debounce");

  a_width_hold: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (st.fsm == ST_EXPOSE && CFG.exposure_control_select == LEXC_EXP_WIDTH && CFG.trigger_enable_setting
     && !end_edge) |=> st.nominal)
    else $error("width exposure closed before the opposite edge");

  a_off_hold: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (st.fsm == ST_EXPOSE && CFG.exposure_control_select == LEXC_EXP_OFF && CFG.trigger_enable_setting
     && !act_edge) |=> st.nominal)
    else $error("off mode window closed inside the period");

  a_off_drop: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (st.fsm == ST_EXPOSE && CFG.exposure_control_select == LEXC_EXP_OFF && act_edge
     && !FRAME_TRIGGER_VALID) |=> !st.nominal && st.fsm == ST_IDLE)
    else $error("off mode chained a line outside a valid frame");

  a_trig_off: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !CFG.trigger_enable_setting |=> !st.nominal)
    else $error("exposure window open while trigger disabled");

  a_start_pulse: assert property (@(posedge CORE_CLK) disable iff (SRST)
    st.start_p |=> !st.start_p)
    else $error("line start longer than one cycle");

  // Shaft source adds no delay: the output trails the window by the two register stages
  sequence s_shaft_rise;
    !is_line && $rose(st.nominal) ##1 !is_line && st.nominal;
  endsequence

  sequence s_shaft_fall;
    !is_line && $fell(st.nominal) ##1 !is_line && !st.nominal;
  endsequence

  a_shaft_rise: assert property (@(posedge CORE_CLK) disable iff (SRST)
    s_shaft_rise |-> ##1 EXPOSURE_ACTIVE)
    else $error("exposure did not open after the shaft window");

  a_shaft_fall: assert property (@(posedge CORE_CLK) disable iff (SRST)
    s_shaft_fall |-> ##1 !EXPOSURE_ACTIVE)
    else $error("exposure did not close after the shaft window");

endmodule // lexc_top

// file: hw/lexc_pkg.sv
// Purpose: Shared constants and types for the line exposure control block.
// Assumes: 125 MHz core clock, one domain.
// Notes:   Times are kept in their printed unit; cycle counts derive from them.
package lexc_pkg;

  localparam int unsigned CLK_MHZ       = 125;
  // Base start/end delay per model, in tenths of a microsecond
  localparam int unsigned BASE_DLY_MIN_TENTH_US = 26;
  localparam int unsigned BASE_DLY_MAX_TENTH_US = 1044;
  localparam int unsigned BASE_DLY_DEF_TENTH_US = 62;
  localparam int unsigned BASE_DLY_DEF_CYC = (BASE_DLY_DEF_TENTH_US * CLK_MHZ) / 10;
  // Least hold time of an input-line level
  localparam int unsigned MIN_HOLD_NS   = 100;
  localparam int unsigned MIN_HOLD_CYC  = (MIN_HOLD_NS * CLK_MHZ + 999) / 1000;

  localparam int CNT_W  = 24;
  localparam int US_W   = 16;
  localparam int DBC_W  = 16;

  localparam logic [US_W-1:0] EXP_US_RESET = 16'h0032;

  typedef enum logic [1:0] {
    LEXC_EXP_WIDTH = 2'b00,
    LEXC_EXP_TIMED = 2'b01,
    LEXC_EXP_OFF   = 2'b10
  } lexc_exp_mode_t;

  typedef enum logic [1:0] {
    LEXC_SRC_LINE1 = 2'b00,
    LEXC_SRC_LINE2 = 2'b01,
    LEXC_SRC_LINE3 = 2'b10,
    LEXC_SRC_SHAFT = 2'b11
  } lexc_src_t;

  typedef struct packed {
    logic           trigger_enable_setting;
    lexc_exp_mode_t exposure_control_select;
    logic           trigger_edge_polarity;   // 1: rising starts a line
    lexc_src_t      trigger_origin_select;
    logic [US_W-1:0] exposure_duration_us;
  } lexc_cfg_t;

endpackage : lexc_pkg

// file: hw/lexc_delay_line.sv
// Purpose: Delays a single-bit level by a programmable count of clock cycles.
// Assumes: Input changes are spaced wider than the delay (one pending edge).
// Notes:   A new edge arriving while one is pending replaces the pending one.
`timescale 1ns/1ps
module lexc_delay_line
  import lexc_pkg::*;
#(
  parameter int W = CNT_W
)
(
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         din,
  input  wire logic [W-1:0] delay,
  output logic              dout
);

  typedef struct packed {
    logic         q;
    logic         last;
    logic         pend;
    logic         val;
    logic [W-1:0] cnt;
  } lexc_dl_st_t;

  lexc_dl_st_t st;
  lexc_dl_st_t next_st;

  always_comb
  begin
    next_st      = st;
    next_st.last = din;
    if (din != st.last)
    begin
      next_st.pend = 1'b1;
      next_st.val  = din;
      next_st.cnt  = delay;
    end
    else if (st.pend)
    begin
      if (st.cnt == '0)
      begin
        next_st.q    = st.val;
        next_st.pend = 1'b0;
      end
      else
        next_st.cnt = st.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      st <= '0;
    else
      st <= next_st;
  end

  assign dout = st.q;

endmodule // lexc_delay_line

// file: verif/lexc_trig_model.sv
// Purpose: Trigger source model: three input lines and the shaft output.
// Assumes: Levels change 1 ns after a clock edge.
// Notes:   Lines that are not selected flip on each change of a selected line; shaft changes leave them alone.
`timescale 1ns/1ps
module lexc_trig_model
  import lexc_pkg::*;
(
  input  wire logic clk,
  output logic [2:0] lines,
  output logic       shaft
);
  initial
  begin
    lines = 3'h0;
    shaft = 1'b0;
  end
  // Shaft is offered in every mode; width mode with it is only advised against
  task automatic set_level(input lexc_src_t src, input logic lvl, input int hold);
    @(posedge clk);
    #1;
    if (src == LEXC_SRC_SHAFT)
      shaft = lvl;
    else
      for (int i = 0; i < 3; i++)
        lines[i] = (i == int'(src)) ? lvl : ~lines[i];
    repeat ((hold > MIN_HOLD_CYC) ? hold : MIN_HOLD_CYC) @(posedge clk);
  endtask
endmodule // lexc_trig_model

// file: verif/lexc_top_test.sv
// Purpose: Self-checking bench for the exposure window block.
// Assumes: Small base delay; debounce set per line at random.
// Notes:   Watcher measures start delay and window length per line start.
`timescale 1ns/1ps
module lexc_top_test;
  import lexc_pkg::*;
  localparam int BASE = 4;
  // Longest per-model minimum exposure, 3.0 us, in clock cycles
  localparam int MIN_EXP_CYC = (30 * int'(CLK_MHZ)) / 10;
  logic                  core_clk, srst, ftv, exp_act, line_start, shaft;
  logic [2:0]            lines;
  lexc_cfg_t             cfg;
  logic [2:0][DBC_W-1:0] dbc;
  int                    num_errors, tests_run, cycles, ls_count, ls_old, got_d, got_w;
  int                    q_d[$], q_w[$];
  logic [31:0]           lfsr = 32'hB60FEADB;

  lexc_trig_model u_lexc_trig_model (.clk(core_clk), .lines(lines), .shaft(shaft));
  lexc_top #(.BASE_DELAY_CYC(BASE)) u_lexc_top (
    .CORE_CLK(core_clk), .SRST(srst), .EXTERNAL_LINE_TRIGGER_IN(lines), .SHAFT_ENCODER_OUT(shaft),
    .FRAME_TRIGGER_VALID(ftv), .CFG(cfg), .DEBOUNCE_CYC(dbc), .EXPOSURE_ACTIVE(exp_act),
    .LINE_START(line_start));

  function automatic int rnd(input int m);
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04C11DB7 : 32'h0);
    return int'(lfsr[15:0]) % m;
  endfunction

  task automatic check(input int got, input int exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One line: idle, active edge, inactive edge, second active edge with frame trigger low
  task automatic run(input lexc_exp_mode_t m, input lexc_src_t s, input logic p);
    int d, hi, lo, tw;
    @(posedge core_clk);
    #1;
    hi = MIN_EXP_CYC + rnd(32);
    tw = int'(cfg.exposure_duration_us) * int'(CLK_MHZ);
    lo = 30 + rnd(16);
    ftv = 1'b0;
    cfg.exposure_control_select = m;
    cfg.trigger_edge_polarity = p;
    cfg.trigger_origin_select = s;
    if (s != LEXC_SRC_SHAFT)
      dbc[int'(s)] = DBC_W'(rnd(8));
    d = (s == LEXC_SRC_SHAFT) ? 0 : BASE + int'(dbc[int'(s)]);
    u_lexc_trig_model.set_level(s, !p, 20);
    #1 ftv = 1'b1;
    q_d.push_back(d + 2);
    q_w.push_back(m == LEXC_EXP_WIDTH ? hi + 1 : m == LEXC_EXP_TIMED ? tw : hi + lo + 2);
    u_lexc_trig_model.set_level(s, p, hi);
    u_lexc_trig_model.set_level(s, !p, lo);
    #1 ftv = 1'b0;
    u_lexc_trig_model.set_level(s, p, 20);
    u_lexc_trig_model.set_level(s, !p, 400);
    $display("test mode %0d src %0d pol %0d done", m, s, p);
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (line_start === 1'b1)
      ls_count++;
    if (cycles >= 60000)
    begin
      num_errors++;
      $display("[FAIL] %0t run did not finish", $time);
      close_out();
    end
  end

  initial forever
  begin
    @(posedge core_clk);
    if (line_start === 1'b1)
    begin
      got_d = 0;
      got_w = 0;
      while (exp_act !== 1'b1 && got_d < 2000)
      begin
        @(posedge core_clk);
        got_d++;
      end
      while (exp_act === 1'b1 && got_w < 2000)
      begin
        @(posedge core_clk);
        got_w++;
      end
      if (q_d.size() == 0)
        check(1, 0, "unexpected line start");
      else
      begin
        check(got_d, q_d.pop_front(), "start delay");
        check(got_w, q_w.pop_front(), "window");
      end
    end
  end

  initial
  begin
    srst = 1'b1;
    ftv = 1'b0;
    cfg = '0;
    dbc = '0;
    cfg.trigger_enable_setting = 1'b1;
    cfg.exposure_duration_us = 16'h0004;
    repeat (6) @(posedge core_clk);
    #1 srst = 1'b0;
    check(int'(exp_act === 1'b0 && line_start === 1'b0), 1, "reset outputs");
    for (int m = 0; m < 3; m++)
      for (int s = 0; s < 4; s++)
        for (int p = 0; p < 2; p++)
          run(lexc_exp_mode_t'(m), lexc_src_t'(s), p[0]);
    #1;
    cfg.trigger_origin_select = LEXC_SRC_LINE1;
    cfg.trigger_edge_polarity = 1'b1;
    u_lexc_trig_model.set_level(LEXC_SRC_LINE1, 1'b0, 20);
    ls_old = ls_count;
    u_lexc_trig_model.set_level(LEXC_SRC_LINE1, 1'b1, 200);
    u_lexc_trig_model.set_level(LEXC_SRC_LINE1, 1'b0, 50);
    #1 ftv = 1'b1;
    cfg.trigger_enable_setting = 1'b0;
    u_lexc_trig_model.set_level(LEXC_SRC_LINE1, 1'b1, 200);
    u_lexc_trig_model.set_level(LEXC_SRC_LINE1, 1'b0, 50);
    check(ls_count, ls_old, "ignored edges");
    $display("test ignored edges done");
    close_out();
  end
endmodule // lexc_top_test
